// ===== dhs_pkg.sv
// Shared constants for the disk head seek control block
package dhs_pkg;

  // ****************************************************************
  // Register map (byte addresses, one 32-bit word each)
  // ****************************************************************
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_TIMING = 8'h04;
  localparam logic [7:0] REG_CONFIG = 8'h08;
  localparam logic [7:0] REG_RESULT = 8'h0c;
  localparam logic [7:0] REG_CYL    = 8'h10;

  // Command word fields
  localparam int F_OP    = 0;   // 4 bits
  localparam int F_DRIVE = 4;   // 2 bits
  localparam int F_DIR   = 6;   // 1 bit
  localparam int F_ARG   = 8;   // 8 bits

  // Timing word fields
  localparam int F_STEP   = 0;  // 4 bits
  localparam int F_UNLOAD = 4;  // 4 bits
  localparam int F_LOAD   = 8;  // 7 bits
  localparam int F_PATH   = 15; // 1 bit
  localparam int F_RATE   = 16; // 2 bits

  // Configuration word fields
  localparam int F_AUTOPOS = 0;
  localparam int F_QOFF    = 1;
  localparam int F_POLLDIS = 2;
  localparam int F_THR     = 4; // 4 bits
  localparam int F_PRECOMP = 8; // 8 bits

  // Result word fields
  localparam int F_RES     = 0;  // 8 bits
  localparam int F_RESCYL  = 8;  // 8 bits
  localparam int F_BUSY    = 16;
  localparam int F_IRQ     = 17;
  localparam int F_DRVBUSY = 18; // 4 bits
  localparam int F_XREADY  = 22;

  // Reset values
  localparam logic [31:0] TIMING_RST = 32'h0000_0000;
  localparam logic [31:0] CONFIG_RST = 32'h0000_0002; // queue bypassed

  // ****************************************************************
  // Commands
  // ****************************************************************
  localparam logic [3:0] CMD_SEEK      = 4'h1;
  localparam logic [3:0] CMD_RELSEEK   = 4'h2;
  localparam logic [3:0] CMD_RECAL     = 4'h3;
  localparam logic [3:0] CMD_SENSE_INT = 4'h4;
  localparam logic [3:0] CMD_SENSE_DRV = 4'h5;
  localparam logic [3:0] CMD_VERSION   = 4'h6;
  localparam logic [3:0] CMD_WAKE      = 4'h7;
  localparam logic [3:0] CMD_XFER_GO   = 4'h8;
  localparam logic [3:0] CMD_XFER_END  = 4'h9;

  // Seek modes
  localparam logic [1:0] MODE_SEEK  = 2'h0;
  localparam logic [1:0] MODE_REL   = 2'h1;
  localparam logic [1:0] MODE_RECAL = 2'h2;

  // ****************************************************************
  // Status byte layout and cause codes
  // ****************************************************************
  localparam int S0_CAUSE = 6; // 2 bits
  localparam int S0_DONE  = 5;
  localparam int S0_FAULT = 4;
  localparam int S0_HEAD  = 2;
  localparam int S3_WPROT = 6;
  localparam int S3_RDY   = 5;
  localparam int S3_TRK0  = 4;
  localparam logic [1:0] CAUSE_NORMAL  = 2'h0;
  localparam logic [1:0] CAUSE_ABNORM  = 2'h1;
  localparam logic [1:0] CAUSE_INVALID = 2'h2;
  localparam logic [1:0] CAUSE_POLL    = 2'h3;

  // Version byte: value is arbitrary
  localparam logic [7:0] VERSION_BYTE = 8'h5a;

  // ****************************************************************
  // Timing (base figures at the slowest data rate)
  // ****************************************************************
  localparam int CLK_KHZ        = 25000;
  localparam int STEP_UNIT_US   = 2000;
  localparam int UNLOAD_UNIT_US = 32000;
  localparam int LOAD_UNIT_US   = 4000;
  localparam int STEP_PULSE_NS  = 4000;
  localparam int STEP_UNIT_CYC   = STEP_UNIT_US * CLK_KHZ / 1000;
  localparam int UNLOAD_UNIT_CYC = UNLOAD_UNIT_US * CLK_KHZ / 1000;
  localparam int LOAD_UNIT_CYC   = LOAD_UNIT_US * CLK_KHZ / 1000;
  localparam int STEP_PULSE_CYC  = (STEP_PULSE_NS * CLK_KHZ + 999999) / 1000000;
  localparam int TMR_W           = 24;
  localparam logic [4:0] STEP_CODES   = 5'h10;
  localparam logic [4:0] UNLOAD_ZERO  = 5'h10;
  localparam logic [7:0] LOAD_ZERO    = 8'h80;
  localparam logic [7:0] RECAL_MAX    = 8'hff;

  // State types
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CHECK = 2'b01,
    ST_PULSE = 2'b11,
    ST_GAP   = 2'b10
  } dhs_step_e;

  typedef enum logic [1:0] {
    X_IDLE = 2'b00,
    X_SEEK = 2'b01,
    X_LOAD = 2'b11,
    X_RUN  = 2'b10
  } dhs_xfer_e;

endpackage

// ===== dhs_seek_ctrl.sv
// Disk head seek and control-command logic with an APB register port
`timescale 1ns/100ps
`default_nettype none

module dhs_seek_ctrl
  import dhs_pkg::*;
#(
  parameter int DRIVES     = 4,
  parameter int STEP_UNIT  = STEP_UNIT_CYC,
  parameter int UNLOAD_UNIT = UNLOAD_UNIT_CYC,
  parameter int LOAD_UNIT  = LOAD_UNIT_CYC
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // Drive side
  input  wire logic [DRIVES-1:0] trackZeroN,
  input  wire logic [DRIVES-1:0] writeProtect,
  output logic [DRIVES-1:0]      stepDir,
  output logic [DRIVES-1:0]      stepPulse,
  output logic                   headLoad,
  // Controller side
  output logic                   irq,
  output logic                   xferReady,
  output logic                   queueBypass,
  output logic [4:0]             queueThreshold,
  output logic [7:0]             precompStartTrack
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rstMeta_q, rstN_q;

  // Assert at once, release after two edges
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_q <= 1'b0;
      rstN_q    <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstN_q    <= rstMeta_q;
    end
  end

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic                  wrAcc, cmdWr;
  logic [3:0]            cmdOp;
  logic [1:0]            cmdDrv;
  logic [7:0]            cmdArg;
  logic [DRIVES-1:0]     startSeek, startRel, startRecal, clrPend;
  logic [DRIVES-1:0]     drvBusy, drvMoving, relActive, drvPend, drvDone, drvFault;
  logic [7:0]            drvCyl [DRIVES];
  logic                  implied, wake;
  logic [1:0]            cmdMode;
  logic [TMR_W-1:0]      stepGap;
  logic [31:0]           timing_q, timing_d, config_q, config_d;

  // Zero wait state slave
  assign pready = 1'b1;
  assign wrAcc  = psel && penable && pwrite;
  assign cmdWr  = wrAcc && (paddr == REG_CMD);
  assign cmdOp  = pwdata[F_OP +: 4];
  assign cmdDrv = pwdata[F_DRIVE +: 2];
  assign cmdArg = pwdata[F_ARG +: 8];

  // Step spacing: scaled base unit times the interval count
  always_comb begin
    logic [4:0] steps;
    steps   = STEP_CODES - {1'b0, timing_q[F_STEP +: 4]};
    stepGap = TMR_W'(steps) * (TMR_W'(STEP_UNIT) >> timing_q[F_RATE +: 2]);
  end

  // ****************************************************************
  // Per-drive step engines
  // ****************************************************************
  for (genvar d = 0; d < DRIVES; d++) begin : g_drv
    dhs_step_e        st_q, st_d;
    logic [7:0]       cyl_q, cyl_d, tgt_q, tgt_d, cnt_q, cnt_d;
    logic [1:0]       mode_q, mode_d;
    logic             dir_q, dir_d, pend_q, pend_d, se_q, se_d, ec_q, ec_d, imp_q, imp_d;
    logic [TMR_W-1:0] tmr_q, tmr_d;
    logic             fin, fault;

    always_comb begin
      st_d   = st_q;
      cyl_d  = cyl_q;
      tgt_d  = tgt_q;
      cnt_d  = cnt_q;
      mode_d = mode_q;
      dir_d  = dir_q;
      pend_d = pend_q;
      se_d   = se_q;
      ec_d   = ec_q;
      imp_d  = imp_q;
      tmr_d  = tmr_q;
      fin    = 1'b0;
      fault  = 1'b0;
      // Clears go first so a finishing seek below still wins
      if (clrPend[d]) begin
        pend_d = 1'b0;
      end
      if (wake) begin
        cyl_d  = 8'h00;
        pend_d = 1'b0;
        se_d   = 1'b0;
        ec_d   = 1'b0;
      end
      unique case (st_q)
        ST_IDLE: begin
          if (startSeek[d] || startRel[d] || startRecal[d]) begin
            mode_d = startRel[d] ? MODE_REL : (startRecal[d] ? MODE_RECAL : MODE_SEEK);
            imp_d  = implied;
            pend_d = 1'b0;
            se_d   = 1'b0;
            ec_d   = 1'b0;
            tgt_d  = cmdArg;
            cnt_d  = startRel[d] ? cmdArg : 8'h00;
            dir_d  = pwdata[F_DIR];
            if (startRecal[d]) begin
              cyl_d = 8'h00;
            end
            st_d = ST_CHECK;
          end
        end
        ST_CHECK: begin
          unique case (mode_q)
            MODE_REL: begin
              if (cnt_q == 8'h00) begin
                fin = 1'b1;
              end else if (!dir_q && cyl_q == 8'h00) begin
                fin   = 1'b1;
                fault = 1'b1;
              end
            end
            MODE_RECAL: begin
              dir_d = 1'b0;
              if (trackZeroN[d]) begin
                fin = 1'b1;
              end else if (cnt_q == RECAL_MAX) begin
                fin   = 1'b1;
                fault = 1'b1;
              end
            end
            default: begin
              if (cyl_q == tgt_q) begin
                fin = 1'b1;
              end else begin
                dir_d = cyl_q < tgt_q;
              end
            end
          endcase
          if (fin) begin
            st_d   = ST_IDLE;
            se_d   = 1'b1;
            ec_d   = fault;
            pend_d = !imp_q;
          end else begin
            tmr_d = TMR_W'(STEP_PULSE_CYC);
            st_d  = ST_PULSE;
          end
        end
        ST_PULSE: begin
          tmr_d = tmr_q - 1'b1;
          if (tmr_q == TMR_W'(1)) begin
            // Recalibrate holds the cylinder at zero while it steps out
            if (mode_q == MODE_RECAL) begin
              cyl_d = 8'h00;
            end else begin
              cyl_d = dir_q ? cyl_q + 8'h01 : cyl_q - 8'h01;
            end
            cnt_d = (mode_q == MODE_REL) ? cnt_q - 8'h01 : cnt_q + 8'h01;
            tmr_d = stepGap;
            st_d  = ST_GAP;
          end
        end
        ST_GAP: begin
          tmr_d = tmr_q - 1'b1;
          if (tmr_q == TMR_W'(1)) begin
            st_d = ST_CHECK;
          end
        end
      endcase
    end

    always_ff @(posedge sys_clk or negedge rstN_q) begin
      if (!rstN_q) begin
        st_q   <= ST_IDLE;
        cyl_q  <= 8'h00;
        tgt_q  <= 8'h00;
        cnt_q  <= 8'h00;
        mode_q <= MODE_SEEK;
        dir_q  <= 1'b0;
        pend_q <= 1'b0;
        se_q   <= 1'b0;
        ec_q   <= 1'b0;
        imp_q  <= 1'b0;
        tmr_q  <= '0;
      end else begin
        st_q   <= st_d;
        cyl_q  <= cyl_d;
        tgt_q  <= tgt_d;
        cnt_q  <= cnt_d;
        mode_q <= mode_d;
        dir_q  <= dir_d;
        pend_q <= pend_d;
        se_q   <= se_d;
        ec_q   <= ec_d;
        imp_q  <= imp_d;
        tmr_q  <= tmr_d;
      end
    end

    // Drive stays busy until its end is sensed; an implied seek frees it as soon as it stops
    assign drvMoving[d] = (st_q != ST_IDLE);
    assign drvBusy[d]   = drvMoving[d] || pend_q;
    assign relActive[d] = drvMoving[d] && (mode_q == MODE_REL);
    assign drvPend[d]   = pend_q;
    assign drvDone[d]   = se_q;
    assign drvFault[d]  = ec_q;
    assign drvCyl[d]    = cyl_q;
    assign stepDir[d]   = dir_q;
    assign stepPulse[d] = (st_q == ST_PULSE);
  end

  // ****************************************************************
  // Command interpreter, timing, configuration and transfer state
  // ****************************************************************
  dhs_xfer_e        xst_q, xst_d;
  logic [1:0]       xDrv_q, xDrv_d;
  logic [TMR_W-1:0] ldTmr_q, ldTmr_d, ulTmr_q, ulTmr_d;
  logic [7:0]       res_q, res_d, resCyl_q, resCyl_d;
  logic             busy_q, busy_d, xPend_q, xPend_d, poll_q, poll_d, arm_q, arm_d;
  logic             headLoaded;

  assign headLoaded = (xst_q != X_IDLE) || (ulTmr_q != '0);

  always_comb begin
    logic       found;
    logic [1:0] pick;
    logic [4:0] ulCode;
    logic [7:0] ldCode;
    logic       drvFree;
    timing_d  = timing_q;
    config_d  = config_q;
    xst_d     = xst_q;
    xDrv_d    = xDrv_q;
    ldTmr_d   = ldTmr_q;
    ulTmr_d   = (ulTmr_q != '0) ? ulTmr_q - 1'b1 : ulTmr_q;
    res_d     = res_q;
    resCyl_d  = resCyl_q;
    busy_d    = cmdWr;
    xPend_d   = xPend_q;
    poll_d    = poll_q;
    arm_d     = arm_q;
    startSeek = '0;
    startRel  = '0;
    startRecal = '0;
    clrPend   = '0;
    implied   = 1'b0;
    wake      = 1'b0;
    found     = 1'b0;
    pick      = 2'h0;
    drvFree   = !drvBusy[cmdDrv];
    ulCode = (timing_q[F_UNLOAD +: 4] == 4'h0) ? UNLOAD_ZERO : {1'b0, timing_q[F_UNLOAD +: 4]};
    ldCode = (timing_q[F_LOAD +: 7] == 7'h00) ? LOAD_ZERO : {1'b0, timing_q[F_LOAD +: 7]};
    // Lowest numbered drive with an unsensed end answers first
    for (int i = DRIVES - 1; i >= 0; i--) begin
      if (drvPend[i]) begin
        found = 1'b1;
        pick  = 2'(i);
      end
    end
    // Single poll interrupt after reset, held off while a head is loaded
    if (arm_q && config_q[F_POLLDIS]) begin
      arm_d = 1'b0;
    end else if (arm_q && !headLoaded) begin
      arm_d  = 1'b0;
      poll_d = 1'b1;
    end
    // Register writes
    if (wrAcc && paddr == REG_TIMING) begin
      timing_d = pwdata;
    end
    if (wrAcc && paddr == REG_CONFIG) begin
      config_d = pwdata;
    end
    // Transfer sequencing: optional seek, head load, run
    unique case (xst_q)
      X_SEEK: begin
        if (!drvMoving[xDrv_q]) begin
          ldTmr_d = TMR_W'(ldCode) * (TMR_W'(LOAD_UNIT) >> timing_q[F_RATE +: 2]);
          xst_d   = X_LOAD;
        end
      end
      X_LOAD: begin
        ldTmr_d = ldTmr_q - 1'b1;
        if (ldTmr_q <= TMR_W'(1)) begin
          xst_d = X_RUN;
        end
      end
      default: ;
    endcase
    // Commands
    if (cmdWr) begin
      unique case (cmdOp)
        CMD_SEEK: begin
          startSeek[cmdDrv] = drvFree;
        end
        CMD_RELSEEK: begin
          startRel[cmdDrv] = drvFree && (relActive == '0);
        end
        CMD_RECAL: begin
          startRecal[cmdDrv] = drvFree;
        end
        CMD_SENSE_INT: begin
          res_d = 8'h00;
          if (found) begin
            clrPend[pick]          = 1'b1;
            res_d[S0_CAUSE +: 2]   = drvFault[pick] ? CAUSE_ABNORM : CAUSE_NORMAL;
            res_d[S0_DONE]         = drvDone[pick];
            res_d[S0_FAULT]        = drvFault[pick];
            res_d[1:0]             = pick;
            resCyl_d               = drvCyl[pick];
          end else if (xPend_q) begin
            xPend_d              = 1'b0;
            res_d[S0_CAUSE +: 2] = CAUSE_NORMAL;
            res_d[1:0]           = xDrv_q;
          end else if (poll_q) begin
            poll_d               = 1'b0;
            res_d[S0_CAUSE +: 2] = CAUSE_POLL;
          end else begin
            res_d[S0_CAUSE +: 2] = CAUSE_INVALID;
          end
        end
        CMD_SENSE_DRV: begin
          res_d           = 8'h00;
          res_d[S3_WPROT] = writeProtect[cmdDrv];
          res_d[S3_RDY]   = 1'b1;
          res_d[S3_TRK0]  = !trackZeroN[cmdDrv];
          res_d[1:0]      = cmdDrv;
          resCyl_d        = drvCyl[cmdDrv];
        end
        CMD_VERSION: begin
          res_d = VERSION_BYTE;
        end
        CMD_WAKE: begin
          wake    = 1'b1;
          xPend_d = 1'b0;
          poll_d  = 1'b0;
          res_d   = 8'h00;
        end
        CMD_XFER_GO: begin
          if (xst_q == X_IDLE && !timing_q[F_PATH]) begin
            xDrv_d = cmdDrv;
            xst_d  = X_SEEK;
            if (config_q[F_AUTOPOS] && !drvMoving[cmdDrv]) begin
              startSeek[cmdDrv] = 1'b1;
              implied           = 1'b1;
            end
          end
        end
        CMD_XFER_END: begin
          if (xst_q != X_IDLE) begin
            xst_d   = X_IDLE;
            xPend_d = 1'b1;
            ulTmr_d = TMR_W'(ulCode) * (TMR_W'(UNLOAD_UNIT) >> timing_q[F_RATE +: 2]);
          end
        end
        default: begin
          res_d = {CAUSE_INVALID, 6'h00};
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstN_q) begin
    if (!rstN_q) begin
      timing_q <= TIMING_RST;
      config_q <= CONFIG_RST;
      xst_q    <= X_IDLE;
      xDrv_q   <= 2'h0;
      ldTmr_q  <= '0;
      ulTmr_q  <= '0;
      res_q    <= 8'h00;
      resCyl_q <= 8'h00;
      busy_q   <= 1'b0;
      xPend_q  <= 1'b0;
      poll_q   <= 1'b0;
      arm_q    <= 1'b1;
    end else begin
      timing_q <= timing_d;
      config_q <= config_d;
      xst_q    <= xst_d;
      xDrv_q   <= xDrv_d;
      ldTmr_q  <= ldTmr_d;
      ulTmr_q  <= ulTmr_d;
      res_q    <= res_d;
      resCyl_q <= resCyl_d;
      busy_q   <= busy_d;
      xPend_q  <= xPend_d;
      poll_q   <= poll_d;
      arm_q    <= arm_d;
    end
  end

  // ****************************************************************
  // Outputs and read-back
  // ****************************************************************
  assign irq               = (drvPend != '0) || xPend_q || poll_q;
  assign headLoad          = headLoaded;
  assign xferReady         = (xst_q == X_RUN);
  assign queueBypass       = config_q[F_QOFF];
  assign queueThreshold    = {1'b0, config_q[F_THR +: 4]} + 5'h01;
  assign precompStartTrack = config_q[F_PRECOMP +: 8];

  // Read mux; unmapped addresses answer with an error and zero data
  always_comb begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    unique case (paddr)
      REG_CMD:    prdata = 32'h0000_0000;
      REG_TIMING: prdata = {14'h0000, timing_q[F_RATE +: 2], timing_q[15:0]};
      REG_CONFIG: prdata = {16'h0000, config_q[15:0]};
      REG_RESULT: begin
        prdata[F_RES +: 8]       = res_q;
        prdata[F_RESCYL +: 8]    = resCyl_q;
        prdata[F_BUSY]           = busy_q;
        prdata[F_IRQ]            = irq;
        prdata[F_DRVBUSY +: 4]   = 4'(drvBusy);
        prdata[F_XREADY]         = xferReady;
      end
      REG_CYL: begin
        for (int i = 0; i < DRIVES; i++) begin
          prdata[8*i +: 8] = drvCyl[i];
        end
      end
      default: pslverr = psel && penable;
    endcase
  end

endmodule

`default_nettype wire

// ===== dhs_drive_model.sv
// Behavioural drives: head position per step pulse and track-zero sense
`timescale 1ns/100ps
`default_nettype none
module dhs_drive_model #(
  parameter int DRIVES = 4
) (
  // Step control from the block
  input  wire logic              sys_clk,
  input  wire logic [DRIVES-1:0] stepDir,
  input  wire logic [DRIVES-1:0] stepPulse,
  // Sense back to the block and to the bench
  output logic [DRIVES-1:0]      trackZeroN,
  output int                     pos [DRIVES]
);
  logic [DRIVES-1:0] prevPulse = '0;
  initial begin
    foreach (pos[i]) pos[i] = 0;
  end
  // One track per rising step edge; the outer stop holds the head at 0
  always @(posedge sys_clk) begin
    foreach (pos[i]) begin
      if (stepPulse[i] && !prevPulse[i]) begin
        pos[i] <= stepDir[i] ? pos[i] + 1 : (pos[i] > 0 ? pos[i] - 1 : 0);
      end
    end
    prevPulse <= stepPulse;
  end
  // Sensor reads low everywhere except the outermost track
  always_comb begin
    foreach (pos[i]) trackZeroN[i] = (pos[i] == 0);
  end
endmodule
`default_nettype wire

// ===== dhs_seek_ctrl_monitor.sv
// Port-level assertions for the seek control block
`timescale 1ns/100ps
`default_nettype none
module dhs_seek_ctrl_monitor
  import dhs_pkg::*;
#(
  parameter int DRIVES = 4
) (
  // Clock, reset and bus
  input wire logic              sys_clk,
  input wire logic              arst_n,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  // Drive and controller side
  input wire logic [DRIVES-1:0] stepDir,
  input wire logic [DRIVES-1:0] stepPulse,
  input wire logic              headLoad,
  input wire logic              irq,
  input wire logic              xferReady,
  input wire logic              queueBypass,
  input wire logic [4:0]        queueThreshold,
  input wire logic [7:0]        precompStartTrack
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Configuration write taken on this edge
  wire cfgWr = psel && penable && pwrite && paddr == REG_CONFIG;
  AST_UNMAPPED: assert property (psel && penable && paddr > REG_CYL |-> pslverr && prdata == 0)
    else $error("unmapped access not refused");
  AST_QOFF: assert property (cfgWr |=> queueBypass == $past(pwdata[F_QOFF]))
    else $error("queue bypass not loaded");
  AST_THR: assert property (cfgWr |=> queueThreshold == $past(pwdata[7:4]) + 5'h1)
    else $error("queue threshold wrong");
  AST_PRECOMP: assert property (cfgWr |=> precompStartTrack == $past(pwdata[15:8]))
    else $error("precompensation track wrong");
  AST_PULSE: assert property ($rose(stepPulse[0]) |=> stepPulse[0] [*8])
    else $error("step pulse too short");
  AST_DIR: assert property ($rose(stepPulse[0]) |=> $stable(stepDir[0]) [*8])
    else $error("direction moved during a step");
  AST_LOAD: assert property (xferReady |-> headLoad)
    else $error("transfer ready without head loaded");
  AST_POLL: assert property ($rose(arst_n) |-> ##[1:8] irq)
    else $error("no poll interrupt after reset");
  COV_IRQ: cover property ($rose(irq));
  COV_XFER: cover property ($rose(xferReady));
  COV_STEP: cover property ($rose(stepPulse[1]));
endmodule
bind dhs_seek_ctrl dhs_seek_ctrl_monitor #(.DRIVES(DRIVES)) i_dhs_seek_ctrl_monitor (
  .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .stepDir(stepDir),
  .stepPulse(stepPulse), .headLoad(headLoad), .irq(irq), .xferReady(xferReady),
  .queueBypass(queueBypass), .queueThreshold(queueThreshold),
  .precompStartTrack(precompStartTrack));
`default_nettype wire

// ===== dhs_seek_ctrl_test.sv
// Self-checking bench for the seek control block
`timescale 1ns/100ps
`default_nettype none
module dhs_seek_ctrl_test;
  import dhs_pkg::*;
  typedef struct { logic [31:0] cmd; logic [15:0] res; int drv; int p; } dhs_row_s;
  logic        sys_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic        pready, pslverr, headLoad, irq, xferReady, queueBypass, errSeen;
  logic [7:0]  paddr = 0, precompStartTrack;
  logic [31:0] pwdata = 0, prdata, r;
  logic [3:0]  trackZeroN, stepDir, stepPulse, writeProtect = 4'h0;
  logic [4:0]  queueThreshold;
  int          pos [4];
  int          numErrors = 0, nChecks = 0;
  // Command word, expected sense word, drive, expected head position
  dhs_row_s rows [6] = '{
    '{32'h0000_0301, 16'h0320, 0, 3}, '{32'h0000_0301, 16'h0320, 0, 3},
    '{32'h0000_0101, 16'h0120, 0, 1}, '{32'h0000_0252, 16'h0221, 1, 2},
    '{32'h0000_0122, 16'h0072, 2, 0}, '{32'h0000_0003, 16'h0020, 0, 0}};
  always #20 sys_clk = ~sys_clk;
  // Short time units keep every step and delay within a few hundred cycles
  dhs_seek_ctrl #(.STEP_UNIT(20), .UNLOAD_UNIT(40), .LOAD_UNIT(10)) i_dhs_seek_ctrl (
    .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .trackZeroN(trackZeroN), .writeProtect(writeProtect), .stepDir(stepDir),
    .stepPulse(stepPulse), .headLoad(headLoad), .irq(irq), .xferReady(xferReady),
    .queueBypass(queueBypass), .queueThreshold(queueThreshold),
    .precompStartTrack(precompStartTrack));
  dhs_drive_model #(.DRIVES(4)) i_dhs_drive_model (.sys_clk(sys_clk), .stepDir(stepDir),
    .stepPulse(stepPulse), .trackZeroN(trackZeroN), .pos(pos));
  // One bus transfer; read data is the value present at the completing edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    nChecks++;
    if (s !== e) begin
      numErrors++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // Bounded wait on a level output
  task automatic waitFor(ref logic s);
    for (int k = 0; k < 5000 && s !== 1'b1; k++) @(posedge sys_clk);
    chk(s, 32'h1);
  endtask
  // Interrupt status command, then the result word
  task automatic sense(input logic [15:0] m, input logic [15:0] e);
    apb(1'b1, REG_CMD, {28'h0, CMD_SENSE_INT});
    apb(1'b0, REG_RESULT, 32'h0);
    chk(r[15:0] & m, e);
  endtask
  task automatic conclude;
    if (numErrors == 0 && nChecks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge sys_clk);
    numErrors++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    chk({queueBypass, queueThreshold, precompStartTrack}, {1'b1, 5'h01, 8'h00});
    repeat (3) @(posedge sys_clk);
    waitFor(irq);
    sense(16'h00c0, 16'h00c0);
    apb(1'b1, REG_TIMING, 32'h0000_010f);
    // One command at a time: start it, wait for the interrupt, sense, check the head position
    foreach (rows[i]) begin
      apb(1'b1, REG_CMD, rows[i].cmd);
      waitFor(irq);
      sense(16'hffff, rows[i].res);
      chk(pos[rows[i].drv], rows[i].p);
    end
    // Two drives stepping at once
    apb(1'b1, REG_CMD, 32'h0000_0101);
    apb(1'b1, REG_CMD, 32'h0000_0131);
    waitFor(irq);
    sense(16'hffff, 16'h0120);
    sense(16'hffff, 16'h0123);
    apb(1'b0, REG_CYL, 32'h0);
    chk(r, 32'h0100_0201);
    apb(1'b1, REG_CMD, 32'h0000_0025);
    apb(1'b0, REG_RESULT, 32'h0);
    chk(r[7:0], 8'h22);
    apb(1'b1, REG_CMD, {28'h0, CMD_VERSION});
    apb(1'b0, REG_RESULT, 32'h0);
    chk(r[7:0], VERSION_BYTE);
    apb(1'b1, REG_CONFIG, 32'h0000_fff0);
    chk({queueBypass, queueThreshold, precompStartTrack}, {1'b0, 5'h10, 8'hff});
    apb(1'b0, 8'h20, 32'h0);
    chk(r, 32'h0);
    chk(errSeen, 32'h1);
    apb(1'b1, REG_CMD, {28'h0, CMD_XFER_GO});
    waitFor(xferReady);
    chk(headLoad, 32'h1);
    apb(1'b1, REG_CMD, {28'h0, CMD_XFER_END});
    waitFor(irq);
    sense(16'h00f0, 16'h0000);
    // Path bit set: the start request must be ignored
    apb(1'b1, REG_TIMING, 32'h0000_810f);
    apb(1'b1, REG_CMD, {28'h0, CMD_XFER_GO});
    repeat (40) @(posedge sys_clk);
    chk(xferReady, 32'h0);
    // Auto position: transfer on drive 0 seeks to track 2 first, silently
    apb(1'b1, REG_TIMING, 32'h0000_010f);
    apb(1'b1, REG_CONFIG, 32'h0000_0001);
    apb(1'b1, REG_CMD, 32'h0000_0208);
    waitFor(xferReady);
    chk(pos[0], 2);
    chk(irq, 32'h0);
    apb(1'b1, REG_CMD, {28'h0, CMD_WAKE});
    apb(1'b0, REG_CYL, 32'h0);
    chk(r, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
